//--- hw/mem_route_pkg.sv
`default_nettype none

package mem_route_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] OFS_PLACEMENT = 8'hE2;
	localparam int PORT_A_PERIPHERAL_IO_ENABLE_BIT = 7;
	localparam int MAIN_DATA_BIT = 4;
	localparam int SEC_DATA_BIT = 3;
	localparam int MAIN_FETCH_BIT = 2;
	localparam int SEC_FETCH_BIT = 1;
	localparam int SRAM_FETCH_BIT = 0;
	localparam logic [7:0] PLACE_MASK = 8'h1F;
	localparam logic [7:0] PLACE_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ************************************************************
	// Types
	// ************************************************************
	// Strobes from the processor core
	typedef struct packed {
		logic rd;
		logic wr;
		logic fetch;
	} strobe_t;

	// Matches of each select; regs needs a data cycle, periph the port A enable
	typedef struct packed {
		logic sram;
		logic regs;
		logic periph;
		logic secFlash;
		logic mainFlash;
	} match_t;

	// Which target owns the cycle
	typedef enum logic [2:0] {
		TGT_NONE = 3'b000,
		TGT_SRAM = 3'b001,
		TGT_REGS = 3'b010,
		TGT_PERIPH = 3'b011,
		TGT_SEC = 3'b100,
		TGT_MAIN = 3'b101
	} target_t;

endpackage

`default_nettype wire

//--- hw/memory_priority_and_space_routing.sv
// Function
// R1 - Higher priority level alone supplies byte
// R2 - Same-level selects never overlap (software)
// R3 - Order: SRAM, secondary flash, main flash
// R4 - Placement register gates all three strobes
// R5 - Placement loaded from nonvolatile value at reset
// R6 - Runtime writes override placement until reset
// R7 - Bit 7 port A peripheral mode, resets zero
// R8 - Bits 4,3 gate data strobes to flashes
// R9 - Bits 2,1 gate fetch strobe to flashes
// R10 - SRAM always data; bit 0 adds fetch
// R11 - Register block ignores fetch cycles
// R12 - Placement register at base plus E2h
// R13 - Unused register locations never written
// R14 - SRAM, registers, peripheral beat any flash
// R15 - Memory enabled only if selected and permitted
`timescale 1ns/1ns
`default_nettype none

module memory_priority_and_space_routing (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rstn,
	// Processor bus
	input  wire logic [15:0]             addr,
	input  wire mem_route_pkg::strobe_t  strobe,
	input  wire logic [7:0]              wdata,
	// Nonvolatile setting and configured base
	input  wire logic [7:0]              nvPlacement,
	input  wire logic [15:0]             regBase,
	// Select matches from the decode PLD
	input  wire logic                    sramSelect,
	input  wire logic                    secondaryFlashSelect,
	input  wire logic                    mainFlashSelect,
	input  wire logic                    peripheralSelect,
	// Routed strobes and register readback
	output var  mem_route_pkg::strobe_t  sramStrobe,
	output var  mem_route_pkg::strobe_t  secFlashStrobe,
	output var  mem_route_pkg::strobe_t  mainFlashStrobe,
	output var  mem_route_pkg::strobe_t  periphStrobe,
	output var  mem_route_pkg::target_t  target,
	output logic [7:0]                   rdata,
	output logic                         rdataValid,
	// Placement state
	output logic [7:0]                   memorySpacePlacement,
	output logic                         portAPeripheralIoEnable
);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	// Mask one strobe set by permission bits
	function automatic mem_route_pkg::strobe_t gate(input mem_route_pkg::strobe_t s,
			input logic dataOk, input logic fetchOk);
		gate.rd = s.rd & dataOk;
		gate.wr = s.wr & dataOk;
		gate.fetch = s.fetch & fetchOk;
	endfunction

	// ************************************************************
	// Address decode and priority
	// ************************************************************
	mem_route_pkg::match_t  match;
	mem_route_pkg::target_t next_target;
	logic [15:0]            regOffset;
	logic                   dataCycle;
	logic                   restoreNv;

	// Register block spans 256 bytes from its base; data strobes only
	assign regOffset = addr - regBase;
	assign dataCycle = strobe.rd | strobe.wr;

	always_comb begin
		match.sram = sramSelect;
		match.regs = (regOffset[15:8] == 8'h00) & dataCycle; // R11
		match.periph = peripheralSelect & portAPeripheralIoEnable;
		match.secFlash = secondaryFlashSelect;
		match.mainFlash = mainFlashSelect;
		// Top level first; flash only when nothing above matches
		if (match.sram) begin // R3
			next_target = mem_route_pkg::TGT_SRAM;
		end else if (match.regs) begin // R14
			next_target = mem_route_pkg::TGT_REGS;
		end else if (match.periph) begin // R14
			next_target = mem_route_pkg::TGT_PERIPH;
		end else if (match.secFlash) begin // R1
			next_target = mem_route_pkg::TGT_SEC;
		end else if (match.mainFlash) begin // R3
			next_target = mem_route_pkg::TGT_MAIN;
		end else begin
			next_target = mem_route_pkg::TGT_NONE;
		end
	end

	// ************************************************************
	// Strobe routing
	// ************************************************************
	mem_route_pkg::strobe_t next_sramStrobe;
	mem_route_pkg::strobe_t next_secStrobe;
	mem_route_pkg::strobe_t next_mainStrobe;
	mem_route_pkg::strobe_t next_periphStrobe;
	mem_route_pkg::strobe_t idle;

	// Blocked strobes simply never reach a memory, so it stays off the bus
	always_comb begin
		idle = '0;
		next_sramStrobe = idle;
		next_secStrobe = idle;
		next_mainStrobe = idle;
		next_periphStrobe = idle;
		case (next_target)
			mem_route_pkg::TGT_SRAM: begin
				next_sramStrobe = gate(strobe, 1'b1,
					memorySpacePlacement[mem_route_pkg::SRAM_FETCH_BIT]); // R10
			end
			mem_route_pkg::TGT_SEC: begin
				next_secStrobe = gate(strobe,
					memorySpacePlacement[mem_route_pkg::SEC_DATA_BIT], // R8
					memorySpacePlacement[mem_route_pkg::SEC_FETCH_BIT]); // R9
			end
			mem_route_pkg::TGT_MAIN: begin
				next_mainStrobe = gate(strobe,
					memorySpacePlacement[mem_route_pkg::MAIN_DATA_BIT], // R8
					memorySpacePlacement[mem_route_pkg::MAIN_FETCH_BIT]); // R9
			end
			mem_route_pkg::TGT_PERIPH: begin
				next_periphStrobe = gate(strobe, 1'b1, 1'b0);
			end
			default: begin
				next_sramStrobe = idle;
			end
		endcase
	end

	// Registered routing; strobes seen one cycle after the bus (R15)
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sramStrobe <= '0;
			secFlashStrobe <= '0;
			mainFlashStrobe <= '0;
			periphStrobe <= '0;
			target <= mem_route_pkg::TGT_NONE;
		end else begin
			sramStrobe <= next_sramStrobe; // R4
			secFlashStrobe <= next_secStrobe; // R4
			mainFlashStrobe <= next_mainStrobe; // R4
			periphStrobe <= next_periphStrobe;
			target <= next_target; // R15
		end
	end

	// ************************************************************
	// Placement register
	// ************************************************************
	logic [7:0] next_placement;
	logic       next_pioEnable;
	logic [7:0] next_rdata;
	logic       next_rdataValid;
	logic       placeHit;

	assign placeHit = (next_target == mem_route_pkg::TGT_REGS)
		& (regOffset[7:0] == mem_route_pkg::OFS_PLACEMENT); // R12

	// Nonvolatile value cannot feed an async reset, so reload on first clock after release
	always_comb begin
		next_placement = memorySpacePlacement;
		next_pioEnable = portAPeripheralIoEnable;
		next_rdata = mem_route_pkg::ZERO_BYTE;
		next_rdataValid = strobe.rd & (next_target == mem_route_pkg::TGT_REGS);
		if (restoreNv) begin
			next_placement = nvPlacement & mem_route_pkg::PLACE_MASK; // R5
		end else if (placeHit & strobe.wr) begin
			next_placement = wdata & mem_route_pkg::PLACE_MASK; // R6
			next_pioEnable = wdata[mem_route_pkg::PORT_A_PERIPHERAL_IO_ENABLE_BIT]; // R7
		end
		if (placeHit & strobe.rd) begin
			next_rdata = {portAPeripheralIoEnable, memorySpacePlacement[6:0]};
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			memorySpacePlacement <= mem_route_pkg::PLACE_RESET;
			portAPeripheralIoEnable <= 1'b0; // R7
			restoreNv <= 1'b1;
			rdata <= mem_route_pkg::ZERO_BYTE;
			rdataValid <= 1'b0;
		end else begin
			memorySpacePlacement <= next_placement;
			portAPeripheralIoEnable <= next_pioEnable;
			restoreNv <= 1'b0;
			rdata <= next_rdata;
			rdataValid <= next_rdataValid;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	property p_sramWins;
		@(posedge clk) disable iff (!rstn)
		sramSelect |=> (target == mem_route_pkg::TGT_SRAM) && secFlashStrobe == '0
			&& mainFlashStrobe == '0;
	endproperty
	a_sramWins: assert property (p_sramWins) else $error("sram not highest"); // R1

	property p_secOverMain;
		@(posedge clk) disable iff (!rstn)
		secondaryFlashSelect && !sramSelect && !match.regs && !match.periph
			|=> target == mem_route_pkg::TGT_SEC && mainFlashStrobe == '0;
	endproperty
	a_secOverMain: assert property (p_secOverMain) else $error("main beat secondary"); // R3

	property p_nvLoad;
		@(posedge clk) disable iff (!rstn)
		restoreNv |=> memorySpacePlacement == ($past(nvPlacement) & mem_route_pkg::PLACE_MASK)
			&& !portAPeripheralIoEnable;
	endproperty
	a_nvLoad: assert property (p_nvLoad) else $error("nv value not loaded"); // R5

	property p_write;
		@(posedge clk) disable iff (!rstn)
		!restoreNv && placeHit && strobe.wr
			|=> memorySpacePlacement == ($past(wdata) & mem_route_pkg::PLACE_MASK)
			&& portAPeripheralIoEnable == $past(wdata[mem_route_pkg::PORT_A_PERIPHERAL_IO_ENABLE_BIT]);
	endproperty
	a_write: assert property (p_write) else $error("placement write lost"); // R6

	property p_mainData;
		@(posedge clk) disable iff (!rstn)
		mainFlashStrobe.rd || mainFlashStrobe.wr
			|-> $past(memorySpacePlacement[mem_route_pkg::MAIN_DATA_BIT]);
	endproperty
	a_mainData: assert property (p_mainData) else $error("main data strobe leaked"); // R8

	property p_fetch;
		@(posedge clk) disable iff (!rstn)
		(mainFlashStrobe.fetch |-> $past(memorySpacePlacement[mem_route_pkg::MAIN_FETCH_BIT]))
			and (secFlashStrobe.fetch
			|-> $past(memorySpacePlacement[mem_route_pkg::SEC_FETCH_BIT]));
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch strobe leaked"); // R9

	property p_sramData;
		@(posedge clk) disable iff (!rstn)
		sramSelect && strobe.rd |=> sramStrobe.rd;
	endproperty
	a_sramData: assert property (p_sramData) else $error("sram read blocked"); // R10

	property p_noFetchRegs;
		@(posedge clk) disable iff (!rstn)
		strobe.fetch && !strobe.rd && !strobe.wr |=> target != mem_route_pkg::TGT_REGS;
	endproperty
	a_noFetchRegs: assert property (p_noFetchRegs) else $error("fetch hit registers"); // R11

endmodule

`default_nettype wire

//--- tb/cpu_bus_model.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_bus_model (
	// Clock and block base
	input  wire logic                   clk,
	input  wire logic [15:0]            regBase,
	// Bus toward the router
	output var  logic [15:0]            addr,
	output var  mem_route_pkg::strobe_t strobe,
	output var  logic [7:0]             wdata
);
	// ******
	// Bus cycles
	// ******
	// Idle bus at time zero
	initial begin
		addr = 16'h0000;
		strobe = 3'h0;
		wdata = 8'h00;
	end

	// One cycle per call, launched on the falling edge
	task automatic cycle(input logic [15:0] a, input logic [2:0] s, input logic [7:0] d);
		logic [15:0] o;
		logic [2:0]  q;
		o = a - regBase;
		q = s;
		// Writes to spare block slots become reads
		if (s[1] && o < 16'h0100 && o != 16'h00E2) begin
			q = 3'h4;
		end
		@(negedge clk);
		addr <= a;
		strobe <= q;
		wdata <= d;
	endtask
endmodule

`default_nettype wire

//--- tb/memory_priority_and_space_routing_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module memory_priority_and_space_routing_tb_top;
	// ******
	// Signals and model state
	// ******
	logic clk, rstn, sramSelect, secondaryFlashSelect, mainFlashSelect, peripheralSelect;
	logic [15:0] addr, regBase;
	logic [7:0] wdata, nvPlacement, rdata, memorySpacePlacement, eRd;
	logic rdataValid, portAPeripheralIoEnable, pio, eV;
	mem_route_pkg::strobe_t strobe, sramStrobe, secFlashStrobe, mainFlashStrobe, periphStrobe;
	mem_route_pkg::target_t target;
	logic [4:0] place;
	logic [14:0] eR;
	logic [31:0] rngState;
	int nFail, samplesChecked;

	memory_priority_and_space_routing i_memory_priority_and_space_routing (.clk(clk),
		.rstn(rstn), .addr(addr), .strobe(strobe), .wdata(wdata), .nvPlacement(nvPlacement),
		.regBase(regBase), .sramSelect(sramSelect), .secondaryFlashSelect(secondaryFlashSelect),
		.mainFlashSelect(mainFlashSelect), .peripheralSelect(peripheralSelect),
		.sramStrobe(sramStrobe), .secFlashStrobe(secFlashStrobe),
		.mainFlashStrobe(mainFlashStrobe), .periphStrobe(periphStrobe), .target(target),
		.rdata(rdata), .rdataValid(rdataValid), .memorySpacePlacement(memorySpacePlacement),
		.portAPeripheralIoEnable(portAPeripheralIoEnable));
	cpu_bus_model i_cpu_bus_model (.clk(clk), .regBase(regBase), .addr(addr),
		.strobe(strobe), .wdata(wdata));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ******
	// Model and checks
	// ******
	function automatic logic [31:0] xs();
		rngState = rngState ^ (rngState << 13);
		rngState = rngState ^ (rngState >> 17);
		rngState = rngState ^ (rngState << 5);
		return rngState;
	endfunction

	task automatic chkRoute(input logic [14:0] g, input logic [14:0] e);
		samplesChecked++;
		if (g !== e) begin
			nFail++;
			$display("[FAIL] %0t route got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chkReg(input logic [17:0] g, input logic [17:0] e);
		samplesChecked++;
		if (g !== e) begin
			nFail++;
			$display("[FAIL] %0t reg got %h exp %h", $time, g, e);
		end
	endtask

	// Winner by fixed priority, then strobes gated by placement
	task automatic predict();
		logic [15:0] o;
		logic [2:0]  t, s;
		o = addr - regBase;
		s = strobe;
		t = sramSelect ? 3'h1 : (o < 16'h0100 && s[2:1] != 2'h0) ? 3'h2 :
			(peripheralSelect && pio) ? 3'h3 : secondaryFlashSelect ? 3'h4 :
			mainFlashSelect ? 3'h5 : 3'h0;
		eR[2:0] = t;
		eR[5:3] = t == 3'h3 ? s & 3'h6 : 3'h0;
		eR[8:6] = t == 3'h5 ? s & {place[4], place[4], place[2]} : 3'h0;
		eR[11:9] = t == 3'h4 ? s & {place[3], place[3], place[1]} : 3'h0;
		eR[14:12] = t == 3'h1 ? s & {2'h3, place[0]} : 3'h0;
		eV = t == 3'h2 && s[2];
		eRd = (eV && o == 16'h00E2) ? {pio, 2'h0, place} : 8'h00;
		if (t == 3'h2 && s[1] && o == 16'h00E2) begin
			place = wdata[4:0];
			pio = wdata[7];
		end
	endtask

	// One bus cycle: drive, check last cycle's answer, predict this one
	task automatic step(input logic [15:0] a, input logic [2:0] s, input logic [7:0] d,
		input logic [3:0] sel);
		logic [14:0] gR;
		logic [17:0] gG;
		i_cpu_bus_model.cycle(a, s, d);
		{sramSelect, secondaryFlashSelect, mainFlashSelect, peripheralSelect} <= sel;
		#1;
		gR = {sramStrobe, secFlashStrobe, mainFlashStrobe, periphStrobe, target};
		gG = {rdataValid, rdata, portAPeripheralIoEnable, memorySpacePlacement};
		chkRoute(gR, eR);
		chkReg(gG, {eV, eRd, pio, 3'h0, place});
		predict();
	endtask

	// Reset held ten cycles, then two idle cycles
	task automatic resetDut(input logic [7:0] nv);
		// Mid-run reset also starts on a falling edge
		if (rstn === 1'b1) @(negedge clk);
		rstn <= 1'b0;
		nvPlacement <= nv;
		{sramSelect, secondaryFlashSelect, mainFlashSelect, peripheralSelect} <= 4'h0;
		repeat (10) i_cpu_bus_model.cycle(16'h0000, 3'h0, 8'h00);
		rstn <= 1'b1;
		place = nv[4:0];
		pio = 1'b0;
		{eR, eV, eRd} = '0;
		repeat (2) step(16'h0000, 3'h0, 8'h00, 4'h0);
	endtask

	// Random traffic, biased toward the placement slot
	task automatic randomRun(input int n);
		logic [31:0] r;
		logic [15:0] a, o;
		logic        sr;
		repeat (n) begin
			r = xs();
			a = r[1:0] == 2'h0 ? regBase + 16'h00E2 : r[31:16];
			o = a - regBase;
			sr = &r[13:12] && o > 16'h00FF;
			// SRAM and peripheral never overlap the block or each other
			step(a, {r[3:2] == 2'h3, r[3:2] == 2'h2, r[3:2] == 2'h1}, r[11:4],
				{sr, r[14], r[15], r[20] && !sr && o > 16'h00FF});
		end
	endtask

	task automatic testDone();
		$display("checked %0d, mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ******
	// Main sequence
	// ******
	initial begin
		nFail = 0;
		samplesChecked = 0;
		rngState = 32'h0000001A;
		regBase = 16'h2000;
		resetDut(8'hEC);
		step(regBase + 16'h00E2, 3'h2, 8'h9F, 4'h0);
		step(regBase + 16'h00E2, 3'h4, 8'h00, 4'h0);
		randomRun(3000);
		resetDut(8'h13);
		randomRun(1000);
		testDone();
	end
endmodule

`default_nettype wire
